// ===== rtl/cpp_spi.sv
// Byte-wide serial master, clock idle low, data sampled on the rising edge
module cpp_spi #(
   parameter int HALF = cpp_pkg::SPI_HALF_CYC
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // Byte request and answer
   input  wire logic       start,
   input  wire logic [7:0] tx_byte,
   output logic            busy,
   output logic            done,
   output logic [7:0]      rx_byte,
   // Serial pins
   output logic            sclk,
   output logic            mosi,
   input  wire logic       miso
);
   import cpp_pkg::*;

   logic [7:0] sh_ff;
   logic [7:0] div_ff;
   logic [2:0] edges_ff;
   logic       tick;

   assign tick = busy && (div_ff == 8'(HALF - 1));

   always_ff @(posedge clk) begin
      if (reset || !busy || tick) begin
         div_ff <= 8'h00;
      end else begin
         div_ff <= div_ff + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         busy     <= 1'b0;
         done     <= 1'b0;
         sclk     <= 1'b0;
         mosi     <= 1'b0;
         edges_ff <= 3'h0;
         sh_ff    <= 8'h00;
         rx_byte  <= 8'h00;
      end else begin
         done <= 1'b0;
         if (!busy && start) begin
            busy     <= 1'b1;
            sh_ff    <= tx_byte;
            mosi     <= tx_byte[7];
            edges_ff <= 3'h0;
         end else if (tick) begin
            if (!sclk) begin
               sclk  <= 1'b1;
               sh_ff <= {sh_ff[6:0], miso};
            end else begin
               sclk <= 1'b0;
               if (edges_ff == 3'h7) begin
                  busy    <= 1'b0;
                  done    <= 1'b1;
                  rx_byte <= sh_ff;
               end else begin
                  edges_ff <= edges_ff + 3'h1;
                  mosi     <= sh_ff[7];
               end
            end
         end
      end
   end

endmodule : cpp_spi

// ===== rtl/cpp_top.sv
// Peripheral pins of the display controller: init, LEDs, flash, control port, thermistor
// Operation
// - Host interrupt shows auto-initialization running, then changes level when finished.
// - Host interrupt pin is not driven while chip reset is held.
// - Both LED enable selects are low during chip reset.
// - LED enable selects stay low through all of auto-initialization.
// - In normal operation the LED select field follows the display sequence.
// - Device masters the flash serial port, select 0 active low, select 1 unused.
// - Device answers as I2C target on its control port once auto-initialization is done; host is controller.
// - Successive approximation thermistor conversion sampling comparator after each RC ramp charge, with drive low.
// - Ramp drive output feeds the Rc_ramp_drive network when thermistor used.
// - Thermistor power enable output switches thermistor power on when enabled.
module cpp_top #(
   parameter int         SEQ_LEN  = cpp_pkg::SEQ_LEN_DEF,
   parameter int         STEP_CYC = cpp_pkg::LED_STEP_CYC,
   parameter logic [6:0] I2C_ADDR = cpp_pkg::I2C_ADDR_DEF
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // Host interrupt
   output logic      host_irq_out,
   output logic      host_irq_oe_n,
   // LED enable selects
   output logic      led_enable_select_0,
   output logic      led_enable_select_1,
   // Flash serial port
   output logic      flash_serial_clock,
   output logic      flash_serial_out,
   input  wire logic flash_serial_in,
   output logic      flash_select_0_n,
   output logic      flash_select_1_n,
   // Control port
   input  wire logic control_port_scl_in,
   output logic      control_port_scl_out,
   output logic      control_port_scl_oe_n,
   input  wire logic control_port_sda_in,
   output logic      control_port_sda_out,
   output logic      control_port_sda_oe_n,
   // Thermistor measurement
   input  wire logic comparator_result_in,
   output logic      rc_ramp_drive,
   output logic      thermistor_power_en
);
   import cpp_pkg::*;

   localparam int CW = (SEQ_LEN > 4) ? $clog2(SEQ_LEN) : 2;

   // Flash loader and serial master
   cpp_init_t     init_ff;
   logic [CW-1:0] cnt_ff;
   logic          spi_start_ff;
   logic [7:0]    spi_tx_ff;
   logic          spi_done;
   logic [7:0]    spi_rx;
   logic [1:0]    seq_mem [SEQ_LEN];
   logic          run;

   assign run = (init_ff == IN_RUN);

   cpp_spi #(
      .HALF    (SPI_HALF_CYC)
   ) u_spi (
      .clk     (clk),
      .reset   (reset),
      .start   (spi_start_ff),
      .tx_byte (spi_tx_ff),
      .busy    (),
      .done    (spi_done),
      .rx_byte (spi_rx),
      .sclk    (flash_serial_clock),
      .mosi    (flash_serial_out),
      .miso    (flash_serial_in)
   );

   always_ff @(posedge clk) begin
      if (reset) begin
         init_ff          <= IN_START;
         cnt_ff           <= '0;
         spi_start_ff     <= 1'b0;
         spi_tx_ff        <= 8'h00;
         flash_select_0_n <= 1'b1;
         flash_select_1_n <= 1'b1;
      end else begin
         spi_start_ff <= 1'b0;
         unique case (init_ff)
            IN_START: begin
               flash_select_0_n <= 1'b0;
               spi_tx_ff        <= FLASH_READ_CMD;
               spi_start_ff     <= 1'b1;
               init_ff          <= IN_CMD;
            end
            IN_CMD: begin
               if (spi_done) begin
                  spi_tx_ff    <= FLASH_ADDR_BYTE;
                  spi_start_ff <= 1'b1;
                  cnt_ff       <= '0;
                  init_ff      <= IN_ADDR;
               end
            end
            IN_ADDR: begin
               if (spi_done) begin
                  spi_start_ff <= 1'b1;
                  if (cnt_ff == CW'(FLASH_ADDR_BYTES - 1)) begin
                     cnt_ff  <= '0;
                     init_ff <= IN_READ;
                  end else begin
                     cnt_ff <= cnt_ff + CW'(1);
                  end
               end
            end
            IN_READ: begin
               if (spi_done) begin
                  if (cnt_ff == CW'(SEQ_LEN - 1)) begin
                     flash_select_0_n <= 1'b1;
                     init_ff          <= IN_RUN;
                  end else begin
                     spi_start_ff <= 1'b1;
                     cnt_ff       <= cnt_ff + CW'(1);
                  end
               end
            end
            IN_RUN: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (init_ff == IN_READ && spi_done) begin
         seq_mem[cnt_ff] <= spi_rx[1:0];
      end
   end

   // Host interrupt: released in reset, busy level while loading, done level after
   always_ff @(posedge clk) begin
      if (reset) begin
         host_irq_oe_n <= 1'b1;
         host_irq_out  <= IRQ_BUSY_LEVEL;
      end else begin
         host_irq_oe_n <= 1'b0;
         host_irq_out  <= run ? IRQ_DONE_LEVEL : IRQ_BUSY_LEVEL;
      end
   end

   // Control port target
   cpp_i2c_t   i2_ff;
   logic       scl_q_ff;
   logic       sda_q_ff;
   logic [3:0] bit_ff;
   logic [7:0] sh_ff;
   logic       rw_ff;
   logic [7:0] cfg_ff;
   logic [7:0] adc_res_ff;
   logic       i2_start;
   logic       i2_stop;
   logic       scl_rise;
   logic       scl_fall;

   assign i2_start = control_port_scl_in && scl_q_ff && sda_q_ff && !control_port_sda_in;
   assign i2_stop  = control_port_scl_in && scl_q_ff && !sda_q_ff && control_port_sda_in;
   assign scl_rise = control_port_scl_in && !scl_q_ff;
   assign scl_fall = !control_port_scl_in && scl_q_ff;

   always_ff @(posedge clk) begin
      if (reset) begin
         scl_q_ff             <= 1'b1;
         sda_q_ff             <= 1'b1;
         control_port_scl_out  <= 1'b0;
         control_port_scl_oe_n <= 1'b1;
         control_port_sda_out  <= 1'b0;
      end else begin
         scl_q_ff <= control_port_scl_in;
         sda_q_ff <= control_port_sda_in;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         i2_ff                 <= I2_IDLE;
         bit_ff                <= 4'h0;
         sh_ff                 <= 8'h00;
         rw_ff                 <= 1'b0;
         cfg_ff                <= CFG_RESET;
         control_port_sda_oe_n <= 1'b1;
      end else if (i2_start) begin
         i2_ff                 <= I2_ADDR;
         bit_ff                <= 4'h0;
         control_port_sda_oe_n <= 1'b1;
      end else if (i2_stop) begin
         i2_ff                 <= I2_IDLE;
         control_port_sda_oe_n <= 1'b1;
      end else begin
         unique case (i2_ff)
            I2_IDLE: begin
            end
            I2_ADDR, I2_WR: begin
               if (scl_rise) begin
                  sh_ff  <= {sh_ff[6:0], control_port_sda_in};
                  bit_ff <= bit_ff + 4'h1;
               end else if (scl_fall && bit_ff == 4'h8) begin
                  bit_ff <= 4'h0;
                  if (i2_ff == I2_WR) begin
                     cfg_ff                <= sh_ff;
                     control_port_sda_oe_n <= 1'b0;
                     i2_ff                 <= I2_WACK;
                  end else if (sh_ff[7:1] == I2C_ADDR && run) begin
                     rw_ff                 <= sh_ff[0];
                     control_port_sda_oe_n <= 1'b0;
                     i2_ff                 <= I2_AACK;
                  end else begin
                     i2_ff <= I2_IDLE;
                  end
               end
            end
            I2_AACK: begin
               if (scl_fall) begin
                  if (rw_ff) begin
                     sh_ff                 <= {adc_res_ff[6:0], 1'b0};
                     control_port_sda_oe_n <= adc_res_ff[7];
                     bit_ff                <= 4'h1;
                     i2_ff                 <= I2_RD;
                  end else begin
                     control_port_sda_oe_n <= 1'b1;
                     bit_ff                <= 4'h0;
                     i2_ff                 <= I2_WR;
                  end
               end
            end
            I2_WACK: begin
               if (scl_fall) begin
                  control_port_sda_oe_n <= 1'b1;
                  i2_ff                 <= I2_WR;
               end
            end
            I2_RD: begin
               if (scl_fall) begin
                  if (bit_ff == 4'h8) begin
                     control_port_sda_oe_n <= 1'b1;
                     i2_ff                 <= I2_RACK;
                  end else begin
                     control_port_sda_oe_n <= sh_ff[7];
                     sh_ff                 <= {sh_ff[6:0], 1'b0};
                     bit_ff                <= bit_ff + 4'h1;
                  end
               end
            end
            I2_RACK: begin
               if (scl_rise) begin
                  i2_ff <= control_port_sda_in ? I2_IDLE : I2_AACK;
               end
            end
         endcase
      end
   end

   // LED sequence stepping
   logic [31:0]   step_ff;
   logic [CW-1:0] idx_ff;

   always_ff @(posedge clk) begin
      if (reset) begin
         step_ff             <= '0;
         idx_ff              <= '0;
         led_enable_select_0 <= 1'b0;
         led_enable_select_1 <= 1'b0;
      end else if (!run || !cfg_ff[CFG_SEQ_RUN_BIT]) begin
         step_ff             <= '0;
         idx_ff              <= '0;
         led_enable_select_0 <= 1'b0;
         led_enable_select_1 <= 1'b0;
      end else begin
         led_enable_select_0 <= seq_mem[idx_ff][0];
         led_enable_select_1 <= seq_mem[idx_ff][1];
         if (step_ff == 32'(STEP_CYC - 1)) begin
            step_ff <= '0;
            idx_ff  <= (idx_ff == CW'(SEQ_LEN - 1)) ? '0 : idx_ff + CW'(1);
         end else begin
            step_ff <= step_ff + 32'h1;
         end
      end
   end

   // Thermistor successive approximation
   cpp_adc_t              adc_ff;
   logic [15:0]           tmr_ff;
   logic [2:0]            abit_ff;
   logic [ADC_BITS-1:0]   acc_ff;
   logic [ADC_BITS-1:0]   trial;
   logic [15:0]           chg_len;
   logic                  adc_en;

   assign adc_en  = run && cfg_ff[CFG_THERM_EN_BIT];
   assign trial   = acc_ff | (ADC_BITS'(1) << abit_ff);
   assign chg_len = 16'(trial) * 16'(RAMP_UNIT_CYC);

   always_ff @(posedge clk) begin
      if (reset) begin
         thermistor_power_en <= 1'b0;
      end else begin
         thermistor_power_en <= adc_en;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         adc_ff        <= AD_OFF;
         tmr_ff        <= 16'h0000;
         abit_ff       <= 3'h0;
         acc_ff        <= '0;
         adc_res_ff    <= 8'h00;
         rc_ramp_drive <= 1'b0;
      end else if (!adc_en) begin
         adc_ff        <= AD_OFF;
         rc_ramp_drive <= 1'b0;
      end else begin
         unique case (adc_ff)
            AD_OFF: begin
               abit_ff <= 3'(ADC_BITS - 1);
               acc_ff  <= '0;
               tmr_ff  <= 16'h0000;
               adc_ff  <= AD_DIS;
            end
            AD_DIS: begin
               if (tmr_ff == 16'(DISCHARGE_CYC - 1)) begin
                  tmr_ff        <= 16'h0000;
                  rc_ramp_drive <= 1'b1;
                  adc_ff        <= AD_CHG;
               end else begin
                  tmr_ff <= tmr_ff + 16'h0001;
               end
            end
            AD_CHG: begin
               if (tmr_ff == chg_len - 16'h0001) begin
                  rc_ramp_drive <= 1'b0;
                  adc_ff        <= AD_SAMP;
               end else begin
                  tmr_ff <= tmr_ff + 16'h0001;
               end
            end
            AD_SAMP: begin
               tmr_ff <= 16'h0000;
               adc_ff <= AD_DIS;
               if (abit_ff == 3'h0) begin
                  adc_res_ff <= comparator_result_in ? trial : acc_ff;
                  acc_ff     <= '0;
                  abit_ff    <= 3'(ADC_BITS - 1);
               end else begin
                  acc_ff  <= comparator_result_in ? trial : acc_ff;
                  abit_ff <= abit_ff - 3'h1;
               end
            end
         endcase
      end
   end

endmodule : cpp_top

// ===== shared/cpp_pkg.sv
// Constants and state types shared by the peripheral pin controller
package cpp_pkg;

   // Clock
   localparam int CLK_MHZ = 200;

   // Flash load during auto-initialization
   localparam logic [7:0] FLASH_READ_CMD   = 8'h03;
   localparam logic [7:0] FLASH_ADDR_BYTE  = 8'h00;
   localparam int         FLASH_ADDR_BYTES = 3;
   localparam int         SEQ_LEN_DEF      = 8;
   localparam int         SPI_HALF_CYC     = 2;

   // LED sequence step time
   localparam int LED_STEP_US  = 1000;
   localparam int LED_STEP_CYC = LED_STEP_US * CLK_MHZ;

   // Thermistor ramp timing
   localparam int RAMP_UNIT_NS   = 20;
   localparam int RAMP_UNIT_CYC  = (RAMP_UNIT_NS * CLK_MHZ + 999) / 1000;
   localparam int DISCHARGE_NS   = 2000;
   localparam int DISCHARGE_CYC  = (DISCHARGE_NS * CLK_MHZ + 999) / 1000;
   localparam int ADC_BITS       = 8;

   // Control port
   localparam logic [6:0] I2C_ADDR_DEF     = 7'h1B;
   localparam int         CFG_THERM_EN_BIT = 0;
   localparam int         CFG_SEQ_RUN_BIT  = 1;
   localparam logic [7:0] CFG_RESET        = 8'h02;

   // Host interrupt levels
   localparam logic IRQ_BUSY_LEVEL = 1'b1;
   localparam logic IRQ_DONE_LEVEL = 1'b0;

   typedef enum logic [2:0] {IN_START, IN_CMD, IN_ADDR, IN_READ, IN_RUN} cpp_init_t;
   typedef enum logic [2:0] {I2_IDLE, I2_ADDR, I2_AACK, I2_WR, I2_WACK, I2_RD, I2_RACK} cpp_i2c_t;
   typedef enum logic [1:0] {AD_OFF, AD_DIS, AD_CHG, AD_SAMP} cpp_adc_t;

endpackage : cpp_pkg

// ===== tb/cpp_flash_model.sv
// Behavioural serial flash answering the init load, mode 0, MSB first
module cpp_flash_model (
   // Serial pins
   input  wire logic   flash_serial_clock,
   input  wire logic   flash_select_0_n,
   input  wire logic   flash_serial_out,
   output logic        flash_serial_in,
   // Command and address seen
   output logic [31:0] header_ff
);
   timeunit 1ns;
   timeprecision 1ps;
   int         bit_cnt = 0;
   logic [7:0] rd_byte;

   initial flash_serial_in = 1'b0;

   always @(negedge flash_select_0_n) bit_cnt = 0;

   always @(posedge flash_serial_clock) begin
      if (!flash_select_0_n) begin
         if (bit_cnt < 32) header_ff = {header_ff[30:0], flash_serial_out};
         bit_cnt++;
      end
   end

   // Byte k holds entry k+1 in its low bits; released line toggles
   always @(negedge flash_serial_clock or posedge flash_select_0_n) begin
      rd_byte = {6'h2A, 2'((bit_cnt - 32) / 8 + 1)};
      if (flash_select_0_n || bit_cnt < 32) flash_serial_in = ~flash_serial_in;
      else flash_serial_in = rd_byte[7 - (bit_cnt - 32) % 8];
   end
endmodule : cpp_flash_model

// ===== tb/cpp_top_bench.sv
// Self-checking bench for the peripheral pin controller
module cpp_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import cpp_pkg::*;
   localparam int         STEP  = 20;
   localparam int         Q     = 4;
   localparam logic [7:0] THERM = 8'h5A;
   logic        clk = 1'b0, reset = 1'b1, scl_drv = 1'b1, sda_drv = 1'b1, cmp = 1'b0, rc_q = 1'b0;
   logic [10:0] ramp = '0;
   logic        irq, irq_oe_n, led0, led1, sclk, mosi, miso, sel0_n, sel1_n;
   logic        scl_o, scl_oe_n, sda_o, sda_oe_n, rc, pwr, scl, sda;
   logic [31:0] header;
   int          n_mismatch = 0;
   int          total_checks = 0;

   always #2.5 clk = ~clk;
   assign scl = scl_drv & (scl_oe_n | scl_o);
   assign sda = sda_drv & (sda_oe_n | sda_o);

   cpp_top #(.STEP_CYC(STEP)) dut_u (.clk(clk), .reset(reset), .host_irq_out(irq),
      .host_irq_oe_n(irq_oe_n), .led_enable_select_0(led0), .led_enable_select_1(led1),
      .flash_serial_clock(sclk), .flash_serial_out(mosi), .flash_serial_in(miso),
      .flash_select_0_n(sel0_n), .flash_select_1_n(sel1_n), .control_port_scl_in(scl),
      .control_port_scl_out(scl_o), .control_port_scl_oe_n(scl_oe_n),
      .control_port_sda_in(sda), .control_port_sda_out(sda_o),
      .control_port_sda_oe_n(sda_oe_n), .comparator_result_in(cmp), .rc_ramp_drive(rc),
      .thermistor_power_en(pwr));

   cpp_flash_model flash_u (.flash_serial_clock(sclk), .flash_select_0_n(sel0_n),
      .flash_serial_out(mosi), .flash_serial_in(miso), .header_ff(header));

   // Comparator: ramp rises one count per charge cycle, held while sampling
   always @(posedge clk) begin
      rc_q <= rc;
      if (rc) ramp <= ramp + 11'd1;
      else if (!rc_q) ramp <= '0;
      cmp <= (ramp <= {1'b0, THERM, 2'b01});
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic i2c_bit(input logic b, output logic got);
      sda_drv <= b;
      tick(Q);
      scl_drv <= 1'b1;
      tick(Q);
      got = sda;
      tick(Q);
      scl_drv <= 1'b0;
      tick(Q);
   endtask : i2c_bit

   task automatic i2c_start;
      sda_drv <= 1'b1;
      tick(Q);
      scl_drv <= 1'b1;
      tick(Q);
      sda_drv <= 1'b0;
      tick(Q);
      scl_drv <= 1'b0;
      tick(Q);
   endtask : i2c_start

   task automatic i2c_stop;
      sda_drv <= 1'b0;
      tick(Q);
      scl_drv <= 1'b1;
      tick(Q);
      sda_drv <= 1'b1;
      tick(Q);
   endtask : i2c_stop

   // Eight bits then the ninth; a read passes 8'hFF and ends with a NACK
   task automatic i2c_byte(input logic [7:0] d, output logic ack, output logic [7:0] rd);
      logic g;
      for (int i = 7; i >= 0; i--) begin
         i2c_bit(d[i], g);
         rd[i] = g;
      end
      i2c_bit(1'b1, g);
      ack = !g;
   endtask : i2c_byte

   task automatic cfg_write(input logic [6:0] a, input logic [7:0] d, output logic [1:0] ack);
      logic [7:0] rd;
      ack = 2'b00;
      i2c_start;
      i2c_byte({a, 1'b0}, ack[1], rd);
      if (ack[1]) i2c_byte(d, ack[0], rd);
      i2c_stop;
   endtask : cfg_write

   task automatic test_reset;
      check(irq_oe_n, 1'b1, "irq released");
      check({led1, led0}, 2'b00, "leds in reset");
      check({sel1_n, sel0_n}, 2'b11, "selects in reset");
      $display("test_reset done");
   endtask : test_reset

   task automatic test_init;
      logic [1:0] ack;
      int n;
      tick(2);
      check(irq, IRQ_BUSY_LEVEL, "irq busy");
      check(irq_oe_n, 1'b0, "irq driven");
      cfg_write(I2C_ADDR_DEF, 8'h00, ack);
      check(ack, 2'b00, "refused during init");
      n = 0;
      while (irq === IRQ_BUSY_LEVEL && n < 2000) begin
         if ({led1, led0} !== 2'b00) check({led1, led0}, 2'b00, "leds during init");
         tick(1);
         n++;
      end
      check(irq, IRQ_DONE_LEVEL, "init done");
      check(header, {FLASH_READ_CMD, {FLASH_ADDR_BYTES{FLASH_ADDR_BYTE}}}, "flash header");
      check(sel0_n, 1'b1, "flash idle");
      $display("test_init done");
   endtask : test_init

   task automatic test_leds;
      logic [1:0] prev;
      int n;
      for (int k = 0; k < 10; k++) begin
         prev = {led1, led0};
         n = 0;
         while ({led1, led0} === prev && n < 4 * STEP) begin
            tick(1);
            n++;
         end
         if (k > 0) check(n, STEP, "step time");
         if (k > 0) check({led1, led0}, 2'(prev + 2'd1), "next entry");
      end
      $display("test_leds done");
   endtask : test_leds

   task automatic test_cfg;
      logic [1:0] ack;
      cfg_write(I2C_ADDR_DEF ^ 7'h01, 8'h03, ack);
      check(ack, 2'b00, "wrong address");
      cfg_write(I2C_ADDR_DEF, 8'h00, ack);
      check(ack, 2'b11, "write acked");
      tick(2 * STEP);
      check({led1, led0}, 2'b00, "sequence stopped");
      check(pwr, 1'b0, "power off");
      cfg_write(I2C_ADDR_DEF, 8'h03, ack);
      tick(2);
      check(pwr, 1'b1, "power on");
      $display("test_cfg done");
   endtask : test_cfg

   task automatic test_adc;
      logic a;
      logic [7:0] v;
      int n;
      v = 8'h00;
      n = 0;
      while (v !== THERM && n < 12) begin
         tick(3000);
         i2c_start;
         i2c_byte({I2C_ADDR_DEF, 1'b1}, a, v);
         check(a, 1'b1, "read addressed");
         i2c_byte(8'hFF, a, v);
         i2c_stop;
         n++;
      end
      check(v, THERM, "conversion result");
      $display("test_adc done");
   endtask : test_adc

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      wrap_up;
   end

   initial begin
      tick(2);
      test_reset;
      tick(2);
      reset <= 1'b0;
      test_init;
      test_leds;
      test_cfg;
      test_adc;
      wrap_up;
   end
endmodule : cpp_top_bench

// ===== tb/cpp_top_checker.sv
// Port assertions for the peripheral pin controller
module cpp_top_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Observed outputs
   input wire logic host_irq_out,
   input wire logic host_irq_oe_n,
   input wire logic led_enable_select_0,
   input wire logic led_enable_select_1,
   input wire logic flash_serial_clock,
   input wire logic flash_select_0_n,
   input wire logic flash_select_1_n,
   input wire logic control_port_scl_oe_n,
   input wire logic control_port_sda_oe_n,
   input wire logic rc_ramp_drive,
   input wire logic thermistor_power_en
);
   timeunit 1ns;
   timeprecision 1ps;
   import cpp_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   irq_release_a: assert property (disable iff (1'b0) reset |=> host_irq_oe_n)
      else $error("irq pin driven in reset");
   led_reset_a: assert property (disable iff (1'b0)
      reset |=> !led_enable_select_0 && !led_enable_select_1)
      else $error("leds not low in reset");
   sel_reset_a: assert property (disable iff (1'b0)
      reset |=> flash_select_0_n && flash_select_1_n)
      else $error("flash selected in reset");
   led_init_a: assert property (host_irq_out == IRQ_BUSY_LEVEL |->
      !led_enable_select_0 && !led_enable_select_1)
      else $error("leds on during init");
   irq_hold_a: assert property (host_irq_out == IRQ_DONE_LEVEL |=>
      host_irq_out == IRQ_DONE_LEVEL)
      else $error("irq returned to busy");
   irq_done_a: assert property (!$past(reset) && $rose(flash_select_0_n) |=>
      host_irq_out == IRQ_DONE_LEVEL)
      else $error("irq not done after load");
   sel_spare_a: assert property (flash_select_1_n)
      else $error("spare select asserted");
   sclk_framed_a: assert property (flash_serial_clock |-> !flash_select_0_n)
      else $error("serial clock outside select");
   sclk_shape_a: assert property ($rose(flash_serial_clock) |->
      flash_serial_clock [*2] ##1 !flash_serial_clock)
      else $error("serial clock high time wrong");
   init_quiet_a: assert property (host_irq_out == IRQ_BUSY_LEVEL |->
      !thermistor_power_en && control_port_sda_oe_n)
      else $error("power or ack during init");
   ramp_power_a: assert property (rc_ramp_drive |-> thermistor_power_en)
      else $error("ramp without thermistor");
   ramp_min_a: assert property ($rose(rc_ramp_drive) |-> rc_ramp_drive [*4])
      else $error("ramp charge too short");
   scl_free_a: assert property (control_port_scl_oe_n)
      else $error("clock line pulled");

   cover property ($fell(host_irq_out));
   cover property ($rose(led_enable_select_1));
   cover property ($fell(control_port_sda_oe_n));
endmodule : cpp_top_checker

bind cpp_top cpp_top_checker chk_u (.clk, .reset, .host_irq_out, .host_irq_oe_n,
   .led_enable_select_0, .led_enable_select_1, .flash_serial_clock, .flash_select_0_n,
   .flash_select_1_n, .control_port_scl_oe_n, .control_port_sda_oe_n, .rc_ramp_drive,
   .thermistor_power_en);
